// ===== src/csl_charger_status.sv
// Upper status bits, power-path selection and alarm of the charger.
// Assumes the SMBus engine supplies control word, voltage code, battery
// voltage and a one-cycle pulse whenever the status word is read.
`timescale 1ns/10ps
module csl_charger_status #(
  parameter int BYPASS_CYC = csl_pkg::BYPASS_CYCLES
) (
  input  wire logic                  I_CLK_SYS,
  input  wire logic                  I_RST,
  input  wire csl_pkg::csl_comp_type I_COMP,
  input  wire logic                  I_CHARGE_ENABLE_PIN,
  input  wire logic [15:0]           I_CONTROL_WORD,
  input  wire logic [15:0]           I_VOLTAGE_CODE,
  input  wire logic [15:0]           I_BAT_MV,
  input  wire logic                  I_STATUS_READ,
  output logic [15:0]                O_STATUS_WORD,
  output logic                       O_ALARM_O,
  output logic                       O_ALARM_OE,
  output logic                       O_HIGH_SIDE_EN,
  output logic                       O_BATTERY_SWITCH_DRIVE,
  output logic                       O_ADAPTER_SWITCH_DRIVE,
  output logic                       O_BYPASS_SWITCH_DRIVE,
  output logic                       O_CHARGE_RUN,
  output logic                       O_WAKE_MODE,
  output logic                       O_FOUR_CELL,
  output logic [6:0]                 O_VOLTAGE_DAC
);
  import csl_pkg::*;

  // ==========================================================================
  // Input synchronisers
  // Comparators are asynchronous to the clock; stage one feeds only stage two.
  logic [COMP_W-1:0] sync1_reg;
  logic [COMP_W-1:0] sync2_reg;
  logic [COMP_W-1:0] sync3_reg;
  logic [COMP_W-1:0] comp_reg;
  logic              pin1_reg;
  logic              pin2_reg;
  logic              pin3_reg;
  logic              pin_reg;
  csl_comp_type      c;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      comp_reg  <= '0;
      pin1_reg  <= 1'b1;
      pin2_reg  <= 1'b1;
      pin3_reg  <= 1'b1;
      pin_reg   <= 1'b1;
    end else begin
      sync1_reg <= I_COMP;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin1_reg  <= I_CHARGE_ENABLE_PIN;
      pin2_reg  <= pin1_reg;
      pin3_reg  <= pin2_reg;
      for (int i = 0; i < COMP_W; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          comp_reg[i] <= sync2_reg[i];
        end
      end
      if (pin2_reg == pin3_reg) begin
        pin_reg <= pin2_reg;
      end
    end
  end

  assign c = csl_comp_type'(comp_reg);

  // ==========================================================================
  // Charge-voltage code decode
  logic        code_wake;
  logic        code_3c;
  logic        code_4c;
  logic        code_high;
  logic        code_bad;
  logic [15:0] code_off;
  logic [15:0] dac_wide;
  logic [6:0]  dac_val;

  always_comb begin
    code_wake = (I_VOLTAGE_CODE == VCODE_WAKE);
    code_3c   = (I_VOLTAGE_CODE >= VCODE_3C_MIN) &&
                (I_VOLTAGE_CODE <= VCODE_3C_MAX);
    code_high = (I_VOLTAGE_CODE > VCODE_4C_MAX);
    code_4c   = ((I_VOLTAGE_CODE >= VCODE_4C_MIN) &&
                 (I_VOLTAGE_CODE <= VCODE_4C_MAX)) || code_high;
    code_bad  = !(code_wake || code_3c || code_4c);
    code_off  = code_3c ? (I_VOLTAGE_CODE - VCODE_3C_MIN)
                        : (I_VOLTAGE_CODE - VCODE_4C_MIN);
    // Integer division truncates, so in-between codes round down.
    dac_wide  = code_3c ? (code_off / VCODE_STEP3)
                        : (code_off / VCODE_STEP4);
    dac_val   = (code_high || dac_wide > 16'(DAC_MAX)) ? DAC_MAX
                                                      : dac_wide[6:0];
    if (!(code_3c || code_4c)) begin
      dac_val = '0;
    end
  end

  // ==========================================================================
  // Depleted threshold scaled by cell count
  logic [15:0] cell_mv;
  logic [15:0] depl_mv;
  logic        depleted;

  always_comb begin
    cell_mv  = DEPL_BASE_MV + 16'(I_CONTROL_WORD[CTL_DEPL_HI:CTL_DEPL_LO]) *
               DEPL_STEP_MV;
    depl_mv  = code_3c ? 16'(cell_mv * 16'h0003) : 16'(cell_mv * 16'h0004);
    depleted = (I_BAT_MV < depl_mv);
  end

  // ==========================================================================
  // Thermal latch and charge gating
  logic thermal_reg;
  logic learn;
  logic charge_ok;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      thermal_reg <= 1'b0;
    end else if (c.tj_above_145) begin
      thermal_reg <= 1'b1;
    end else if (c.tj_below_130) begin
      thermal_reg <= 1'b0;
    end
  end

  assign learn = I_CONTROL_WORD[CTL_LEARN];
  assign charge_ok = !I_CONTROL_WORD[CTL_END_CHARGE] && !pin_reg &&
                     c.adapter_detect_input_above_2v4 && c.ts_battery_detect &&
                     !code_bad && !thermal_reg;

  // ==========================================================================
  // Power-path selection
  logic learn_left_reg;
  logic bat_sw;
  logic ac_sw;

  // Once learn is abandoned on depletion it stays on adapter until learn drops.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      learn_left_reg <= 1'b0;
    end else if (!learn) begin
      learn_left_reg <= 1'b0;
    end else if (depleted && c.adapter_detect_input_above_2v4) begin
      learn_left_reg <= 1'b1;
    end
  end

  always_comb begin
    bat_sw = (!c.adapter_detect_input_above_2v4 || (learn && !learn_left_reg)) &&
             !depleted && !c.sys_above_bat_150;
    ac_sw  = c.adapter_detect_input_above_2v4 && (!learn || learn_left_reg ||
             depleted) && !c.adapter_overcurrent;
  end

  // ==========================================================================
  // Bypass reverse-discharge protection
  logic        bypass_reg;
  logic [31:0] deg_cnt_reg;

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      bypass_reg  <= 1'b0;
      deg_cnt_reg <= '0;
    end else if (c.input_below_bat_150) begin
      bypass_reg  <= 1'b0;
      deg_cnt_reg <= '0;
    end else if (!c.input_above_bat_250) begin
      deg_cnt_reg <= '0;
    end else if (!bypass_reg) begin
      if (deg_cnt_reg >= 32'(BYPASS_CYC - 1)) begin
        bypass_reg <= 1'b1;
      end else begin
        deg_cnt_reg <= deg_cnt_reg + 32'h1;
      end
    end
  end

  // ==========================================================================
  // Status word, outputs and alarm
  logic [15:0] status_next;
  logic        alarm_reg;

  always_comb begin
    status_next = '0;
    status_next[BIT_CUR_IDLE]  = !(charge_ok && c.cur_loop_active);
    status_next[BIT_DPM_IDLE]  = !(charge_ok && c.dpm_loop_active);
    status_next[BIT_CHG_OC]    = c.chg_overcurrent;
    status_next[BIT_BAT_SW]    = bat_sw;
    status_next[BIT_AC_SW]     = ac_sw;
    status_next[BIT_THERMAL]   = thermal_reg;
    status_next[BIT_COLD]      = c.ts_above_cold;
    status_next[BIT_HOT]       = O_CHARGE_RUN ? c.ts_below_hot_run
                                              : c.ts_below_hot_start;
    status_next[BIT_DEPLETED]  = depleted;
    status_next[BIT_VOR]       = code_bad;
    status_next[BIT_BAT_ABOVE] = c.bat_above_input;
    status_next[BIT_BAT_PRES]  = c.ts_battery_detect;
    status_next[BIT_AC_DET]    = c.adapter_detect_input_above_2v4;
    status_next[2:0]           = LOW_BITS_ZERO;
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      O_STATUS_WORD          <= 16'h0018;
      O_HIGH_SIDE_EN         <= 1'b0;
      O_BATTERY_SWITCH_DRIVE <= 1'b0;
      O_ADAPTER_SWITCH_DRIVE <= 1'b0;
      O_CHARGE_RUN           <= 1'b0;
      O_WAKE_MODE            <= 1'b0;
      O_FOUR_CELL            <= 1'b0;
      O_VOLTAGE_DAC          <= '0;
    end else begin
      O_STATUS_WORD          <= status_next;
      // Cut while chg_overcurrent is high; not latched, so it returns the cycle after it clears.
      O_HIGH_SIDE_EN         <= charge_ok && !c.chg_overcurrent;
      O_BATTERY_SWITCH_DRIVE <= bat_sw;
      O_ADAPTER_SWITCH_DRIVE <= ac_sw;
      O_CHARGE_RUN           <= charge_ok;
      O_WAKE_MODE            <= code_wake;
      O_FOUR_CELL            <= code_4c;
      O_VOLTAGE_DAC          <= dac_val;
    end
  end

  assign O_BYPASS_SWITCH_DRIVE = bypass_reg;

  // A change in the read cycle wins so it is not lost.
  always_ff @(posedge I_CLK_SYS) begin
    if (I_RST) begin
      alarm_reg <= 1'b0;
    end else if (status_next != O_STATUS_WORD) begin
      alarm_reg <= 1'b1;
    end else if (I_STATUS_READ) begin
      alarm_reg <= 1'b0;
    end
  end

  assign O_ALARM_O  = 1'b0;
  assign O_ALARM_OE = alarm_reg;

  // ==========================================================================
  // Assertions
  sequence s_change;
    status_next != O_STATUS_WORD;
  endsequence

  property p_alarm_set;
    @(posedge I_CLK_SYS) disable iff (I_RST) s_change |=> O_ALARM_OE;
  endproperty
  a_alarm_set: assert property (p_alarm_set) else $error("no alarm");

  property p_alarm_clr;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      (I_STATUS_READ && status_next == O_STATUS_WORD) |=> !O_ALARM_OE;
  endproperty
  a_alarm_clr: assert property (p_alarm_clr) else $error("alarm held");

  property p_vor;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      code_bad |=> O_STATUS_WORD[BIT_VOR] && !O_CHARGE_RUN;
  endproperty
  a_vor: assert property (p_vor) else $error("bad code accepted");

  property p_oc;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      c.chg_overcurrent |=> !O_HIGH_SIDE_EN && O_STATUS_WORD[BIT_CHG_OC];
  endproperty
  a_oc: assert property (p_oc) else $error("driver on in fault");

  property p_adapter_overcurrent;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      c.adapter_overcurrent |=> !O_ADAPTER_SWITCH_DRIVE;
  endproperty
  a_adapter_overcurrent: assert property (p_adapter_overcurrent) else $error("adapter switch on");

  property p_sys_hold;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      c.sys_above_bat_150 |=> !O_BATTERY_SWITCH_DRIVE;
  endproperty
  a_sys_hold: assert property (p_sys_hold) else $error("bat switch on");

  property p_thermal;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      c.tj_above_145 |=> ##1 (O_STATUS_WORD[BIT_THERMAL] && !O_CHARGE_RUN);
  endproperty
  a_thermal: assert property (p_thermal) else $error("no shutdown");

  property p_bypass;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      c.input_below_bat_150 |=> !O_BYPASS_SWITCH_DRIVE;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass on");

  property p_pin;
    @(posedge I_CLK_SYS) disable iff (I_RST) pin_reg |=> !O_CHARGE_RUN;
  endproperty
  a_pin: assert property (p_pin) else $error("charging with pin high");

  property p_paths;
    @(posedge I_CLK_SYS) disable iff (I_RST)
      O_STATUS_WORD[BIT_BAT_SW] == O_BATTERY_SWITCH_DRIVE &&
      O_STATUS_WORD[BIT_AC_SW] == O_ADAPTER_SWITCH_DRIVE;
  endproperty
  a_paths: assert property (p_paths) else $error("mirror mismatch");

endmodule // csl_charger_status

// ===== shared/csl_pkg.sv
// Constants and carrier types for the charger status word and selector.
// Assumes comparator outputs arrive as digital levels from the analog side.
package csl_pkg;

  // ==========================================================================
  // Status word bit positions
  localparam int BIT_CUR_IDLE  = 3;
  localparam int BIT_DPM_IDLE  = 4;
  localparam int BIT_CHG_OC    = 5;
  localparam int BIT_BAT_SW    = 6;
  localparam int BIT_AC_SW     = 7;
  localparam int BIT_THERMAL   = 8;
  localparam int BIT_COLD      = 9;
  localparam int BIT_HOT       = 10;
  localparam int BIT_DEPLETED  = 11;
  localparam int BIT_VOR       = 12;
  localparam int BIT_BAT_ABOVE = 13;
  localparam int BIT_BAT_PRES  = 14;
  localparam int BIT_AC_DET    = 15;
  localparam int STATUS_W      = 16;
  localparam logic [2:0] LOW_BITS_ZERO = 3'h0;

  // ==========================================================================
  // Charge-voltage code windows, in millivolts.
  localparam logic [15:0] VCODE_WAKE   = 16'h2328;
  localparam logic [15:0] VCODE_3C_MIN = 16'h2ee0;
  localparam logic [15:0] VCODE_3C_MAX = 16'h3840;
  localparam logic [15:0] VCODE_4C_MIN = 16'h3e80;
  localparam logic [15:0] VCODE_4C_MAX = 16'h4b00;
  localparam logic [15:0] VCODE_STEP3  = 16'h0013;
  localparam logic [15:0] VCODE_STEP4  = 16'h0019;
  localparam logic [6:0]  DAC_MAX      = 7'h7f;

  // Per-cell depleted threshold base and step, in millivolts.
  localparam logic [15:0] DEPL_BASE_MV = 16'h0898;
  localparam logic [15:0] DEPL_STEP_MV = 16'h0064;

  // Control word bit positions.
  localparam int CTL_END_CHARGE = 0;
  localparam int CTL_LEARN      = 4;
  localparam int CTL_DEPL_LO    = 9;
  localparam int CTL_DEPL_HI    = 11;

  // ==========================================================================
  // Deglitch before the bypass switch may return.
  localparam int  BYPASS_DEGLITCH_MS = 8;
  localparam int  CLK_KHZ            = 100000;
  localparam int  BYPASS_CYCLES      = BYPASS_DEGLITCH_MS * CLK_KHZ;
  localparam int  SYNC_STAGES        = 3;

  typedef struct packed {
    logic cur_loop_active;
    logic dpm_loop_active;
    logic chg_overcurrent;
    logic adapter_overcurrent;
    logic tj_above_145;
    logic tj_below_130;
    logic ts_above_cold;
    logic ts_below_hot_start;
    logic ts_below_hot_run;
    logic ts_battery_detect;
    logic adapter_detect_input_above_2v4;
    logic bat_above_input;
    logic input_below_bat_150;
    logic input_above_bat_250;
    logic sys_above_bat_150;
  } csl_comp_type;
  localparam int COMP_W = 15;

endpackage

// ===== test/csl_host_model.sv
// Host controller model that answers the alarm by reading the status word.
// Assumes the bench resolves the open-drain alarm wire with a pull-up.
`timescale 1ns/10ps
module csl_host_model #(
  parameter int DLY = 20
) (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_alarm_n,
  input  wire logic [15:0] i_word,
  output logic             o_read,
  output logic [15:0]      o_word
);
  // ==========================================================================
  // Read on alarm
  int cnt;

  // A slow host leaves the alarm standing, so DLY sets how long it waits.
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      cnt <= 0;
      o_read <= 1'b0;
      o_word <= 16'h0;
    end else if (o_read) begin
      o_read <= 1'b0;
      o_word <= i_word;
      cnt <= 0;
    end else if (!i_alarm_n) begin
      cnt <= cnt + 1;
      if (cnt >= DLY) o_read <= 1'b1;
    end else begin
      cnt <= 0;
    end
  end
endmodule // csl_host_model

// ===== test/csl_charger_status_tb.sv
// Self-checking bench for the charger status word and power selector.
// Assumes comparator levels settle through the sync within eight cycles.
`timescale 1ns/10ps
module csl_charger_status_tb;
  import csl_pkg::*;
  localparam logic [15:0] VOK = 16'h3840;
  localparam logic [15:0] BOK = 16'h2ee0;
  logic         clk, rst, pin, rd, alm_o, alm_oe, hs;
  logic         bsw, asw, byp, run, wake, four;
  logic [6:0]   dac;
  logic [15:0]  ctl, code, bat, st, hw;
  csl_comp_type comp;
  csl_comp_type c;
  int           miscompares, n_checks, i;
  wire          alarm_n = alm_oe ? alm_o : 1'b1;

  csl_charger_status #(.BYPASS_CYC(10)) DUT (
    .I_CLK_SYS              (clk),
    .I_RST                  (rst),
    .I_COMP                 (comp),
    .I_CHARGE_ENABLE_PIN    (pin),
    .I_CONTROL_WORD         (ctl),
    .I_VOLTAGE_CODE         (code),
    .I_BAT_MV               (bat),
    .I_STATUS_READ          (rd),
    .O_STATUS_WORD          (st),
    .O_ALARM_O              (alm_o),
    .O_ALARM_OE             (alm_oe),
    .O_HIGH_SIDE_EN         (hs),
    .O_BATTERY_SWITCH_DRIVE (bsw),
    .O_ADAPTER_SWITCH_DRIVE (asw),
    .O_BYPASS_SWITCH_DRIVE  (byp),
    .O_CHARGE_RUN           (run),
    .O_WAKE_MODE            (wake),
    .O_FOUR_CELL            (four),
    .O_VOLTAGE_DAC          (dac)
  );
  csl_host_model #(.DLY(20)) host (
    .i_clk     (clk),
    .i_rst     (rst),
    .i_alarm_n (alarm_n),
    .i_word    (st),
    .o_read    (rd),
    .o_word    (hw)
  );

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  function automatic csl_comp_type good();
    csl_comp_type r;
    r = '0;
    r.adapter_detect_input_above_2v4 = 1'b1;
    r.ts_battery_detect = 1'b1;
    r.input_above_bat_250 = 1'b1;
    return r;
  endfunction

  task automatic go(input csl_comp_type x, input logic p,
                    input logic [15:0] k, v, b);
    @(posedge clk);
    comp <= x;
    pin <= p;
    ctl <= k;
    code <= v;
    bat <= b;
    repeat (8) @(posedge clk);
  endtask

  task automatic end_sim;
    $display("miscompares %0d n_checks %0d", miscompares, n_checks);
    if (miscompares == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_loops;
    c = good();
    c.cur_loop_active = 1'b1;
    c.dpm_loop_active = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(run, 1'b1);
    chk(st[BIT_CUR_IDLE], 1'b0);
    chk(st[BIT_DPM_IDLE], 1'b0);
    go(c, 1'b1, 16'h0, VOK, BOK);
    chk(run, 1'b0);
    chk(st[BIT_CUR_IDLE], 1'b1);
    chk(st[BIT_DPM_IDLE], 1'b1);
    go(c, 1'b0, 16'h0001, VOK, BOK);
    chk(run, 1'b0);
  endtask

  task automatic t_thermal;
    c = good();
    c.tj_above_145 = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_THERMAL], 1'b1);
    chk(run, 1'b0);
    c.tj_above_145 = 1'b0;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_THERMAL], 1'b1);
    c.tj_below_130 = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_THERMAL], 1'b0);
    chk(run, 1'b1);
  endtask

  task automatic t_flags;
    c = good();
    c.ts_above_cold = 1'b1;
    c.bat_above_input = 1'b1;
    c.ts_below_hot_start = 1'b1;
    go(c, 1'b1, 16'h0, VOK, BOK);
    chk(st[BIT_COLD], 1'b1);
    chk(st[BIT_BAT_ABOVE], 1'b1);
    chk(st[BIT_HOT], 1'b1);
    c = good();
    c.ts_below_hot_start = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_HOT], 1'b0);
    chk(st[BIT_COLD], 1'b0);
    c = good();
    c.ts_battery_detect = 1'b0;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_BAT_PRES], 1'b0);
    chk(run, 1'b0);
    c = good();
    c.adapter_detect_input_above_2v4 = 1'b0;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(st[BIT_AC_DET], 1'b0);
    chk(run, 1'b0);
  endtask

  task automatic t_codes;
    logic [15:0] cv [5];
    logic [6:0]  ed [5];
    cv = '{16'h1000, 16'h3a98, 16'h2f05, 16'h3eb2, 16'h5000};
    ed = '{7'h0, 7'h0, 7'h01, 7'h02, 7'h7f};
    for (i = 0; i < 5; i++) begin
      go(good(), 1'b0, 16'h0, cv[i], BOK);
      chk(st[BIT_VOR], i < 2);
      chk(run, i > 1);
      if (i > 1) chk(dac, ed[i]);
      if (i > 1) chk(four, i > 2);
    end
    go(good(), 1'b0, 16'h0, VCODE_WAKE, BOK);
    chk(wake, 1'b1);
    chk(st[BIT_VOR], 1'b0);
  endtask

  task automatic t_path;
    c = good();
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk({bsw, asw, st[BIT_BAT_SW], st[BIT_AC_SW]}, 4'b0101);
    go(c, 1'b0, 16'h0010, VOK, BOK);
    chk({bsw, asw, st[BIT_BAT_SW], st[BIT_AC_SW]}, 4'b1010);
    go(c, 1'b0, 16'h0010, VOK, 16'h1770);
    chk({bsw, asw, st[BIT_DEPLETED]}, 3'b011);
    go(c, 1'b0, 16'h0200, VOK, 16'h1af3);
    chk(st[BIT_DEPLETED], 1'b1);
    go(c, 1'b0, 16'h0200, VOK, 16'h1af4);
    chk(st[BIT_DEPLETED], 1'b0);
    go(c, 1'b0, 16'h0200, VCODE_4C_MAX, 16'h23ef);
    chk(st[BIT_DEPLETED], 1'b1);
    c.sys_above_bat_150 = 1'b1;
    go(c, 1'b0, 16'h0010, VOK, BOK);
    chk(bsw, 1'b0);
    c = good();
    c.adapter_overcurrent = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(asw, 1'b0);
    c.adapter_detect_input_above_2v4 = 1'b0;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk({bsw, st[BIT_BAT_SW]}, 2'b11);
  endtask

  task automatic t_oc;
    logic seen;
    c = good();
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(hs, 1'b1);
    c.chg_overcurrent = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    seen = 1'b0;
    repeat (8) begin
      @(negedge clk);
      if (hs === 1'b0) seen = 1'b1;
    end
    chk(seen, 1'b1);
    chk(st[BIT_CHG_OC], 1'b1);
    c.chg_overcurrent = 1'b0;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(hs, 1'b1);
    chk(st[BIT_CHG_OC], 1'b0);
  endtask

  task automatic t_alarm_bypass;
    c = good();
    go(c, 1'b0, 16'h0, VOK, BOK);
    repeat (40) @(posedge clk);
    chk(alarm_n, 1'b1);
    chk(byp, 1'b1);
    c.input_below_bat_150 = 1'b1;
    c.input_above_bat_250 = 1'b0;
    c.bat_above_input = 1'b1;
    go(c, 1'b0, 16'h0, VOK, BOK);
    chk(byp, 1'b0);
    chk(alarm_n, 1'b0);
    repeat (30) @(posedge clk);
    chk(alarm_n, 1'b1);
    chk(hw, st);
    go(good(), 1'b0, 16'h0, VOK, BOK);
    chk(byp, 1'b0);
    repeat (12) @(posedge clk);
    chk(byp, 1'b1);
  endtask

  // ==========================================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    rst = 1'b1;
    pin = 1'b1;
    comp = '0;
    ctl = 16'h0;
    code = VOK;
    bat = BOK;
    miscompares = 0;
    n_checks = 0;
    repeat (12) @(posedge clk);
    chk(st, 16'h0018);
    rst <= 1'b0;
    t_loops();
    t_thermal();
    t_flags();
    t_codes();
    t_path();
    t_oc();
    t_alarm_bypass();
    end_sim();
  end

  // The whole run needs well under a thousand cycles; this is ample margin.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // csl_charger_status_tb
